// File: hw/bace_exec.sv
// Purpose: Decode and execute the AND-immediate-to-direct and carry AND bit instructions.
// Assumes: Fetch offers one byte per valid pulse; memory answers reads in the same cycle.
// Notes: Other opcodes are left to the rest of the core.
// Operation
// - 53h direct imm: write direct AND imm
// - Zero source bit clears carry
// - Slash form uses inverted bit, unchanged
// - Carry AND changes only carry flag
// - Source bit only by direct address
// - 82h plus bit address, two cycles
// - B0h plus bit address, two cycles
`timescale 1ns/10ps
module bace_exec (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic fetch_valid_i,
  input wire logic [7:0] fetch_byte_i,
  output logic fetch_ready_o,
  output logic [7:0] dir_addr_o,
  input wire logic [7:0] dir_rdata_i,
  output logic dir_we_o,
  output logic [7:0] dir_wdata_o,
  output logic [7:0] bit_addr_o,
  input wire logic bit_rdata_i,
  input wire logic carry_i,
  output logic carry_we_o,
  output logic carry_o,
  output logic busy_o,
  output logic done_o
);
  // ==========================================================================
  // Decode helpers
  function automatic logic bace_is_bitop(input logic [7:0] op);
    bace_is_bitop = (op == bace_pkg::OP_AND_C_BIT) || (op == bace_pkg::OP_AND_C_NBIT);
  endfunction : bace_is_bitop

  function automatic logic bace_is_mine(input logic [7:0] op);
    bace_is_mine = bace_is_bitop(op) || (op == bace_pkg::OP_AND_DIR_IMM);
  endfunction : bace_is_mine

  bace_pkg::bace_state_t state_q;
  logic [7:0] op_q;
  logic [7:0] addr_q;
  logic [7:0] imm_q;
  logic [1:0] mc_q;
  logic mc_tick;
  logic take;

  bace_mc_div u_div (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .mc_tick_o(mc_tick)
  );

  // Bytes are only taken while the decoder waits for them.
  assign fetch_ready_o = (state_q == bace_pkg::BACE_IDLE) || (state_q == bace_pkg::BACE_OPND1) ||
    (state_q == bace_pkg::BACE_OPND2);
  assign take = fetch_valid_i && fetch_ready_o;
  assign busy_o = (state_q != bace_pkg::BACE_IDLE);

  // ==========================================================================
  // Sequencer
  // Instruction length follows the opcode: three bytes or two bytes.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= bace_pkg::BACE_IDLE;
    end else begin
      unique case (state_q)
        bace_pkg::BACE_IDLE: begin
          if (take && bace_is_mine(fetch_byte_i)) begin
            state_q <= bace_pkg::BACE_OPND1;
          end
        end
        bace_pkg::BACE_OPND1: begin
          if (take) begin
            // Second byte is always a direct or bit address.
            state_q <= bace_is_bitop(op_q) ? bace_pkg::BACE_EXEC : bace_pkg::BACE_OPND2;
          end
        end
        bace_pkg::BACE_OPND2: begin
          if (take) begin
            state_q <= bace_pkg::BACE_EXEC;
          end
        end
        bace_pkg::BACE_EXEC: begin
          // Completion waits for two machine cycles to expire.
          // A stalled fetch may let the count saturate first; the next tick still ends it.
          if (mc_tick && (mc_q >= bace_pkg::EXEC_MC - 2'h1)) begin
            state_q <= bace_pkg::BACE_DONE;
          end
        end
        bace_pkg::BACE_DONE: begin
          state_q <= bace_pkg::BACE_IDLE;
        end
      endcase
    end
  end

  // Operand capture.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      op_q <= 8'h00;
      addr_q <= 8'h00;
      imm_q <= 8'h00;
    end else if (take) begin
      if (state_q == bace_pkg::BACE_IDLE) begin
        op_q <= fetch_byte_i;
      end
      if (state_q == bace_pkg::BACE_OPND1) begin
        addr_q <= fetch_byte_i;
      end
      if (state_q == bace_pkg::BACE_OPND2) begin
        imm_q <= fetch_byte_i;
      end
    end
  end

  // Machine cycles spent since the opcode was taken.
  always_ff @(posedge mclk_i) begin
    if (rst_i || (state_q == bace_pkg::BACE_IDLE)) begin
      mc_q <= 2'h0;
    end else if (mc_tick && (mc_q != bace_pkg::EXEC_MC)) begin
      mc_q <= mc_q + 2'h1;
    end
  end

  // ==========================================================================
  // Execution, in the single DONE cycle
  logic is_done;
  logic src_bit;
  assign is_done = (state_q == bace_pkg::BACE_DONE);
  assign done_o = is_done;
  assign dir_addr_o = addr_q;
  assign bit_addr_o = addr_q;
  // Slash form inverts only the copy used here; memory is never written.
  assign src_bit = (op_q == bace_pkg::OP_AND_C_NBIT) ? ~bit_rdata_i : bit_rdata_i;

  // Byte write-back of direct AND immediate.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      dir_we_o <= 1'b0;
      dir_wdata_o <= 8'h00;
    end else begin
      dir_we_o <= is_done && (op_q == bace_pkg::OP_AND_DIR_IMM);
      dir_wdata_o <= dir_rdata_i & imm_q;
    end
  end

  // Carry is the only flag touched; zero source clears, else carry kept.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      carry_we_o <= 1'b0;
      carry_o <= 1'b0;
    end else begin
      carry_we_o <= is_done && bace_is_bitop(op_q);
      carry_o <= carry_i & src_bit;
    end
  end

  // ==========================================================================
  // Checks
  sequence s_bit_fetch;
    take && (state_q == bace_pkg::BACE_OPND1) && bace_is_bitop(op_q);
  endsequence

  a_byte_writeback: assert property (@(posedge mclk_i) disable iff (rst_i)
    is_done && (op_q == bace_pkg::OP_AND_DIR_IMM) |=> dir_we_o && (dir_wdata_o == ($past(dir_rdata_i) & imm_q)))
    else $error("byte AND write-back wrong");
  a_carry_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
    is_done && bace_is_bitop(op_q) && !src_bit |=> carry_we_o && !carry_o)
    else $error("carry not cleared");
  a_carry_keep: assert property (@(posedge mclk_i) disable iff (rst_i)
    is_done && bace_is_bitop(op_q) && src_bit |=> carry_o == $past(carry_i))
    else $error("carry not kept");
  a_inv_source: assert property (@(posedge mclk_i) disable iff (rst_i)
    is_done && (op_q == bace_pkg::OP_AND_C_NBIT) |=> !dir_we_o && (carry_o == ($past(carry_i) & ~$past(bit_rdata_i))))
    else $error("inverted source wrong");
  a_only_carry: assert property (@(posedge mclk_i) disable iff (rst_i)
    carry_we_o |-> !dir_we_o)
    else $error("bit op wrote a byte");
  a_bit_addr_src: assert property (@(posedge mclk_i) disable iff (rst_i)
    take && (state_q == bace_pkg::BACE_OPND1) |=> bit_addr_o == $past(fetch_byte_i))
    else $error("bit address not from operand");
  a_bit_two_bytes: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_bit_fetch |=> (state_q == bace_pkg::BACE_EXEC) && !fetch_ready_o)
    else $error("bit op length wrong");
  a_two_mcycles: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(busy_o) |-> !done_o [*8] ##1 busy_o ##[5:16] done_o)
    else $error("execution time wrong");

  // Byte form must ask for a third byte before it may execute.
  sequence s_byte_fetch;
    take && (state_q == bace_pkg::BACE_OPND1) && (op_q == bace_pkg::OP_AND_DIR_IMM);
  endsequence

  // Completion is a single pulse that frees the fetch path at once.
  sequence s_back_to_idle;
    !done_o && !busy_o && fetch_ready_o;
  endsequence

  a_byte_three: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_byte_fetch |=> (state_q == bace_pkg::BACE_OPND2) && fetch_ready_o)
    else $error("byte op length wrong");
  a_done_pulse: assert property (@(posedge mclk_i) disable iff (rst_i)
    done_o |=> s_back_to_idle)
    else $error("done not a single pulse");
  // Only the DONE cycle of the byte form may write; any other write would corrupt memory.
  a_no_stray_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    dir_we_o |-> $past(is_done) && ($past(op_q) == bace_pkg::OP_AND_DIR_IMM))
    else $error("unexpected byte write");
  a_write_one_pulse: assert property (@(posedge mclk_i) disable iff (rst_i)
    dir_we_o |=> !dir_we_o)
    else $error("byte write longer than one cycle");
  a_carry_we_src: assert property (@(posedge mclk_i) disable iff (rst_i)
    carry_we_o |-> $past(is_done) && bace_is_bitop($past(op_q)))
    else $error("unexpected carry write");
  // An opcode outside this set leaves the sequencer idle for the rest of the core.
  a_bad_op_ignored: assert property (@(posedge mclk_i) disable iff (rst_i)
    take && (state_q == bace_pkg::BACE_IDLE) && !bace_is_mine(fetch_byte_i) |=> !busy_o)
    else $error("foreign opcode started a sequence");
  // Completion lands on a machine-cycle boundary, never between ticks.
  a_mc_aligned: assert property (@(posedge mclk_i) disable iff (rst_i)
    done_o |-> $past(mc_tick))
    else $error("completion off machine-cycle boundary");
endmodule : bace_exec

// File: hw/bace_mc_div.sv
// Purpose: Machine cycle divider producing a one-clock enable pulse.
// Assumes: Synchronous active-high reset.
// Notes: The pulse marks the last clock of each machine cycle.
`timescale 1ns/10ps
module bace_mc_div (
  input wire logic mclk_i,
  input wire logic rst_i,
  output logic mc_tick_o
);
  logic [3:0] cnt_q;

  // Free-running count; wraps at the machine-cycle length.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
    end else if (cnt_q == bace_pkg::MC_LAST) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  assign mc_tick_o = (cnt_q == bace_pkg::MC_LAST);
endmodule : bace_mc_div

// File: hw/bace_pkg.sv
// Purpose: Shared constants for the bitwise AND and carry execution block.
// Assumes: One core clock; one machine cycle is a fixed number of clocks.
// Notes: Opcodes, lengths and cycle counts are named once here.
package bace_pkg;
  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_AND_DIR_IMM = 8'h53;
  localparam logic [7:0] OP_AND_C_BIT = 8'h82;
  localparam logic [7:0] OP_AND_C_NBIT = 8'hB0;
  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PER_MC = 12;
  localparam logic [3:0] MC_LAST = 4'(CLK_PER_MC - 1);
  localparam logic [1:0] EXEC_MC = 2'h2;
  localparam logic [1:0] LEN_BYTE_OP = 2'h3;
  localparam logic [1:0] LEN_BIT_OP = 2'h2;
  // ==========================================================================
  // States
  typedef enum logic [4:0] {
    BACE_IDLE = 5'h01,
    BACE_OPND1 = 5'h02,
    BACE_OPND2 = 5'h04,
    BACE_EXEC = 5'h08,
    BACE_DONE = 5'h10
  } bace_state_t;
endpackage : bace_pkg

// File: verif/bace_exec_bench.sv
// Purpose: Self-checking bench for the AND immediate and carry AND bit executor.
// Assumes: Operand bytes go on consecutive clocks; memory and carry inputs hold for a whole instruction.
// Notes: The machine cycle divider runs free, so completion is checked against a window.
`timescale 1ns/10ps
module bace_exec_bench;
  // ==========================================================================
  // Stimulus and observed signals
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic fetch_valid_i = 1'b0;
  logic [7:0] fetch_byte_i = 8'h00;
  logic [7:0] dir_rdata_i = 8'h00;
  logic bit_rdata_i = 1'b0;
  logic carry_i = 1'b0;
  logic fetch_ready_o, dir_we_o, carry_we_o, carry_o, busy_o, done_o;
  logic [7:0] dir_addr_o, dir_wdata_o, bit_addr_o;
  logic [31:0] r;
  logic [7:0] ops [3] = '{bace_pkg::OP_AND_DIR_IMM, bace_pkg::OP_AND_C_BIT, bace_pkg::OP_AND_C_NBIT};
  int err_total = 0;
  int num_checks = 0;

  bace_exec uut (.mclk_i(mclk_i), .rst_i(rst_i), .fetch_valid_i(fetch_valid_i), .fetch_byte_i(fetch_byte_i),
    .fetch_ready_o(fetch_ready_o), .dir_addr_o(dir_addr_o), .dir_rdata_i(dir_rdata_i), .dir_we_o(dir_we_o),
    .dir_wdata_o(dir_wdata_o), .bit_addr_o(bit_addr_o), .bit_rdata_i(bit_rdata_i), .carry_i(carry_i),
    .carry_we_o(carry_we_o), .carry_o(carry_o), .busy_o(busy_o), .done_o(done_o));

  // Free-running 200 MHz clock.
  always #2.5 mclk_i = ~mclk_i;

  // ==========================================================================
  // Checking helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // A complemented source inverts the bit before it gates the carry.
  function automatic logic carry_exp(input logic c, input logic b, input logic neg);
    return c & (b ^ neg);
  endfunction : carry_exp

  // ==========================================================================
  // One whole instruction, then its completion window and write-back.
  task automatic run_op(input logic [7:0] op, input logic [7:0] adr, input logic [7:0] imm,
                        input logic [7:0] mem, input logic b, input logic c);
    int n;
    logic byte_op;
    byte_op = (op == bace_pkg::OP_AND_DIR_IMM);
    @(posedge mclk_i);
    fetch_valid_i <= 1'b1;
    fetch_byte_i <= op;
    dir_rdata_i <= mem;
    bit_rdata_i <= b;
    carry_i <= c;
    @(posedge mclk_i);
    fetch_byte_i <= adr;
    if (byte_op) begin
      @(posedge mclk_i);
      fetch_byte_i <= imm;
    end
    @(posedge mclk_i);
    fetch_valid_i <= 1'b0;
    fetch_byte_i <= ~adr;
    n = byte_op ? 3 : 2;
    while (done_o !== 1'b1 && n < 40) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk(8'(n <= 25 && n >= 14), 8'h01);
    chk({7'h00, fetch_ready_o}, 8'h00);
    if (n >= 40) begin
      return;
    end
    @(posedge mclk_i);
    #1;
    chk({7'h00, dir_we_o}, {7'h00, byte_op});
    chk({7'h00, carry_we_o}, {7'h00, ~byte_op});
    if (byte_op) begin
      chk(dir_addr_o, adr);
      chk(dir_wdata_o, mem & imm);
    end else begin
      chk(bit_addr_o, adr);
      chk({7'h00, carry_o}, {7'h00, carry_exp(c, b, op == bace_pkg::OP_AND_C_NBIT)});
    end
  endtask : run_op

  // A byte outside the three opcodes must not start anything.
  task automatic bad_op(input logic [7:0] op);
    logic [7:0] o;
    o = op;
    if (o == ops[0] || o == ops[1] || o == ops[2]) begin
      o = o ^ 8'h01;
    end
    @(posedge mclk_i);
    fetch_valid_i <= 1'b1;
    fetch_byte_i <= o;
    @(posedge mclk_i);
    fetch_valid_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    chk({7'h00, busy_o}, 8'h00);
  endtask : bad_op

  // ==========================================================================
  // Main sequence: reset, twelve-entry corner table, random traffic, bad opcodes.
  initial begin
    void'($urandom(32'h4892f804));
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk({6'h00, fetch_ready_o, busy_o}, 8'h02);
    run_op(ops[0], 8'hFF, 8'h00, 8'hFF, 1'b0, 1'b0);
    run_op(ops[0], 8'h00, 8'hFF, 8'hA5, 1'b1, 1'b1);
    for (int i = 0; i < 12; i++) begin
      run_op(ops[i % 3], 8'(i * 37), 8'hC3, 8'h5A, i[2], i[3]);
    end
    for (int i = 0; i < 30; i++) begin
      r = $urandom;
      run_op(ops[r % 3], 8'($urandom), 8'($urandom), 8'($urandom), r[4], r[5]);
    end
    for (int i = 0; i < 6; i++) begin
      bad_op(8'($urandom));
    end
    print_verdict();
  end
endmodule : bace_exec_bench
